//--- design/fasf_map.vh
// constants for the float abs / sign-flags unit and its register map
// assumes inclusion by every design file of the block
`ifndef FASF_MAP_VH
`define FASF_MAP_VH
`define FASF_OPC_ABS        8'h73
`define FASF_OPC_SIGN       8'h99
`define FASF_ABS_LAT        2'h3
`define FASF_FLAG_W         7
`define FASF_DBZ_BIT        0
`define FASF_INX_BIT        1
`define FASF_UNF_BIT        2
`define FASF_OVF_BIT        3
`define FASF_INV_BIT        4
`define FASF_IFZ_BIT        5
`define FASF_OFZ_BIT        6
`define FASF_ADDR_PSW       4'h0
`define FASF_ADDR_IRQ_STAT  4'h4
`define FASF_ADDR_IRQ_MASK  4'h8
`define FASF_ADDR_CTRL      4'hc
`define FASF_RESP_OKAY      2'h0
`define FASF_RESP_SLVERR    2'h2
`define FASF_QNAN           32'h7fc00000
`define FASF_ABS_MASK       32'h7fffffff
`endif

//--- design/fasf_classify.v
// classifies a single-precision operand: denormal, signalling nan, nan
// assumes a combinational use on the core clock
`timescale 1ns/1ns
`include "fasf_map.vh"
module fasf_classify (
   opnd,
   is_denorm,
   is_snan,
   is_nan
);
   input  wire [31:0] opnd;
   output wire        is_denorm;
   output wire        is_snan;
   output wire        is_nan;

   wire exp_zero = (opnd[30:23] == 8'h00);
   wire exp_ones = (opnd[30:23] == 8'hff);
   wire frac_nz  = (opnd[22:0] != 23'h000000);

   assign is_denorm = exp_zero & frac_nz;
   assign is_nan    = exp_ones & frac_nz;
   assign is_snan   = is_nan & ~opnd[22];
endmodule // fasf_classify

//--- design/fasf_abs_pipe.v
// pipe stages carrying abs result, flags and write enable ahead of the unit's output flops
// assumes clock enable freezes the stages
`timescale 1ns/1ns
`include "fasf_map.vh"
module fasf_abs_pipe (
   aclk,
   aresetn,
   ce,
   in_vld,
   in_res,
   in_flg,
   out_vld,
   out_res,
   out_flg
);
   input  wire                    aclk;
   input  wire                    aresetn;
   input  wire                    ce;
   input  wire                    in_vld;
   input  wire [31:0]             in_res;
   input  wire [`FASF_FLAG_W-1:0] in_flg;
   output wire                    out_vld;
   output wire [31:0]             out_res;
   output wire [`FASF_FLAG_W-1:0] out_flg;

   // the unit's output flops are the last latency stage, so the pipe is one stage short
   localparam DEPTH = `FASF_ABS_LAT - 1;

   wire [DEPTH:0]                     vld_c;
   wire [32*(DEPTH+1)-1:0]            res_c;
   wire [`FASF_FLAG_W*(DEPTH+1)-1:0]  flg_c;

   assign vld_c[0]                      = in_vld;
   assign res_c[31:0]                   = in_res;
   assign flg_c[`FASF_FLAG_W-1:0]       = in_flg;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1)
      begin : stg
         reg                    vld_ff;
         reg [31:0]             res_ff;
         reg [`FASF_FLAG_W-1:0] flg_ff;
         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               vld_ff <= 1'b0;
               res_ff <= 32'h00000000;
               flg_ff <= {`FASF_FLAG_W{1'b0}};
            end
            else if (ce)
            begin
               vld_ff <= vld_c[g];
               res_ff <= res_c[32*g +: 32];
               flg_ff <= flg_c[`FASF_FLAG_W*g +: `FASF_FLAG_W];
            end
         end
         assign vld_c[g+1]                                 = vld_ff;
         assign res_c[32*(g+1) +: 32]                      = res_ff;
         assign flg_c[`FASF_FLAG_W*(g+1) +: `FASF_FLAG_W]  = flg_ff;
      end
   endgenerate
   assign out_vld = vld_c[DEPTH];
   assign out_res = res_c[32*DEPTH +: 32];
   assign out_flg = flg_c[`FASF_FLAG_W*DEPTH +: `FASF_FLAG_W];
endmodule // fasf_abs_pipe

//--- design/fasf_unit.v
// float absolute value and sign-flags execution unit with status word
// assumes issue logic on aclk; software reaches status over axi4-lite
// What this block does
// - abs issue (opcode 115) returns the magnitude after 3 cycles.
// - a denormal abs input becomes zero and sets the input-flushed flag.
// - abs exceptions set sticky status flags cleared only by a status write.
// - status flags update in the cycle the abs destination is written.
// - simultaneous updates are ored together with the existing flags.
// - a zero guard lsb suppresses both abs write and flag update.
// - the abs-flags companion returns the flags a lone abs would produce.
// - sign-flags (opcode 153) returns the sign exception vector after 1 cycle.
// - vector bits: dbz 0, inx 1, unf 2, ovf 3, inv 4, ifz 5, ofz 6, rest zero.
// - sign-flags never touches the status word flags.
// - a denormal sign-flags operand becomes zero and sets input-flushed.
// - a zero guard lsb keeps the sign-flags destination unwritten.
`timescale 1ns/1ns
`include "fasf_map.vh"
module fasf_unit (
   aclk,
   aresetn,
   ce,
   abs_issue,
   abs_flags_only,
   abs_src,
   abs_guarded,
   abs_guard,
   sgn_issue,
   sgn_src,
   sgn_guarded,
   sgn_guard,
   ext_flag_upd,
   abs_wr_ff,
   abs_res_ff,
   sgn_wr_ff,
   sgn_res_ff,
   status_word_ff,
   irq_ff,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input  wire                    aclk;
   input  wire                    aresetn;
   input  wire                    ce;
   input  wire                    abs_issue;
   input  wire                    abs_flags_only;
   input  wire [31:0]             abs_src;
   input  wire                    abs_guarded;
   input  wire [31:0]             abs_guard;
   input  wire                    sgn_issue;
   input  wire [31:0]             sgn_src;
   input  wire                    sgn_guarded;
   input  wire [31:0]             sgn_guard;
   input  wire [`FASF_FLAG_W-1:0] ext_flag_upd;
   output reg                     abs_wr_ff;
   output reg  [31:0]             abs_res_ff;
   output reg                     sgn_wr_ff;
   output reg  [31:0]             sgn_res_ff;
   output reg  [`FASF_FLAG_W-1:0] status_word_ff;
   output reg                     irq_ff;
   input  wire [3:0]              s_axi_awaddr;
   input  wire                    s_axi_awvalid;
   output reg                     s_axi_awready;
   input  wire [31:0]             s_axi_wdata;
   input  wire [3:0]              s_axi_wstrb;
   input  wire                    s_axi_wvalid;
   output reg                     s_axi_wready;
   output reg  [1:0]              s_axi_bresp;
   output reg                     s_axi_bvalid;
   input  wire                    s_axi_bready;
   input  wire [3:0]              s_axi_araddr;
   input  wire                    s_axi_arvalid;
   output reg                     s_axi_arready;
   output reg  [31:0]             s_axi_rdata;
   output reg  [1:0]              s_axi_rresp;
   output reg                     s_axi_rvalid;
   input  wire                    s_axi_rready;

   // guard lsb decides; an unguarded issue counts as guard one
   function guard_ok;
      input       guarded;
      input [31:0] guard;
      begin
         guard_ok = ~guarded | guard[0];
      end
   endfunction

   // flags of the abs operation on its own
   wire abs_den;
   wire abs_snan;
   wire abs_nan;
   fasf_classify u_cls_abs (
      .opnd      (abs_src),
      .is_denorm (abs_den),
      .is_snan   (abs_snan),
      .is_nan    (abs_nan)
   );
   wire sgn_den;
   wire sgn_nan;
   // sign-flags treats every nan alike, so the signalling flag is left open
   fasf_classify u_cls_sgn (
      .opnd      (sgn_src),
      .is_denorm (sgn_den),
      .is_snan   (),
      .is_nan    (sgn_nan)
   );

   reg [`FASF_FLAG_W-1:0] abs_flg;
   reg [31:0]             abs_val;
   reg [`FASF_FLAG_W-1:0] sgn_flg;
   always @*
   begin
      abs_flg = {`FASF_FLAG_W{1'b0}};
      abs_flg[`FASF_IFZ_BIT] = abs_den;
      abs_flg[`FASF_INV_BIT] = abs_snan;
      if (abs_den)
         abs_val = 32'h00000000;
      else if (abs_snan)
         abs_val = abs_src | `FASF_QNAN;
      else if (abs_nan)
         abs_val = abs_src;
      else
         abs_val = abs_src & `FASF_ABS_MASK;
      // any nan compared for sign is invalid; denormal compares as zero
      sgn_flg = {`FASF_FLAG_W{1'b0}};
      sgn_flg[`FASF_IFZ_BIT] = sgn_den;
      sgn_flg[`FASF_INV_BIT] = sgn_nan;
   end

   // companion returns flags as the result and leaves the status word alone
   wire        abs_go  = abs_issue & guard_ok(abs_guarded, abs_guard);
   wire [31:0] abs_in  = abs_flags_only ? {{(32-`FASF_FLAG_W){1'b0}}, abs_flg} : abs_val;
   wire [`FASF_FLAG_W-1:0] abs_upd = abs_flags_only ? {`FASF_FLAG_W{1'b0}} : abs_flg;

   wire                    p_vld;
   wire [31:0]             p_res;
   wire [`FASF_FLAG_W-1:0] p_flg;
   fasf_abs_pipe u_pipe (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .in_vld  (abs_go),
      .in_res  (abs_in),
      .in_flg  (abs_upd),
      .out_vld (p_vld),
      .out_res (p_res),
      .out_flg (p_flg)
   );

   // registers: status word, interrupt status and mask
   reg [`FASF_FLAG_W-1:0] irq_stat_ff;
   reg [`FASF_FLAG_W-1:0] irq_mask_ff;
   reg                    aw_got_ff;
   reg                    w_got_ff;
   reg [3:0]              aw_addr_ff;
   reg [31:0]             w_data_ff;
   reg [3:0]              w_strb_ff;

   wire do_wr = aw_got_ff & w_got_ff & ~s_axi_bvalid;
   wire wr_lo = do_wr & w_strb_ff[0];
   wire [`FASF_FLAG_W-1:0] wflg = w_data_ff[`FASF_FLAG_W-1:0];
   wire [`FASF_FLAG_W-1:0] evt = (p_vld ? p_flg : {`FASF_FLAG_W{1'b0}}) | ext_flag_upd;

   reg [`FASF_FLAG_W-1:0] nxt_status;
   reg [`FASF_FLAG_W-1:0] nxt_irq_stat;
   always @*
   begin
      nxt_status = status_word_ff;
      if (wr_lo && aw_addr_ff == `FASF_ADDR_PSW)
         nxt_status = wflg;
      // sticky or: new events win over a simultaneous write
      nxt_status = nxt_status | evt;
      nxt_irq_stat = irq_stat_ff;
      if (wr_lo && aw_addr_ff == `FASF_ADDR_IRQ_STAT)
         nxt_irq_stat = irq_stat_ff & ~wflg;
      nxt_irq_stat = nxt_irq_stat | evt;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         abs_wr_ff      <= 1'b0;
         abs_res_ff     <= 32'h00000000;
         sgn_wr_ff      <= 1'b0;
         sgn_res_ff     <= 32'h00000000;
         status_word_ff <= {`FASF_FLAG_W{1'b0}};
         irq_stat_ff    <= {`FASF_FLAG_W{1'b0}};
         irq_mask_ff    <= {`FASF_FLAG_W{1'b0}};
         irq_ff         <= 1'b0;
      end
      else if (ce)
      begin
         abs_wr_ff <= p_vld;
         if (p_vld)
            abs_res_ff <= p_res;
         // sign-flags result; status word is never fed from here
         sgn_wr_ff <= sgn_issue & guard_ok(sgn_guarded, sgn_guard);
         if (sgn_issue & guard_ok(sgn_guarded, sgn_guard))
            sgn_res_ff <= {{(32-`FASF_FLAG_W){1'b0}}, sgn_flg};
         status_word_ff <= nxt_status;
         irq_stat_ff    <= nxt_irq_stat;
         if (wr_lo && aw_addr_ff == `FASF_ADDR_IRQ_MASK)
            irq_mask_ff <= wflg;
         irq_ff <= |(nxt_irq_stat & ((wr_lo && aw_addr_ff == `FASF_ADDR_IRQ_MASK) ? wflg : irq_mask_ff));
      end
   end

   // axi4-lite write: address and data taken in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FASF_RESP_OKAY;
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         aw_addr_ff    <= 4'h0;
         w_data_ff     <= 32'h00000000;
         w_strb_ff     <= 4'h0;
      end
      else if (ce)
      begin
         s_axi_awready <= ~aw_got_ff & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_got_ff & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_got_ff  <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_ff == `FASF_ADDR_CTRL) ? `FASF_RESP_SLVERR : `FASF_RESP_OKAY;
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
         end
      end
   end

   // axi4-lite read; ctrl offset is unmapped and answers slverr
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `FASF_RESP_OKAY;
      end
      else if (ce)
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `FASF_RESP_OKAY;
            case (s_axi_araddr)
               `FASF_ADDR_PSW:      s_axi_rdata <= {{(32-`FASF_FLAG_W){1'b0}}, status_word_ff};
               `FASF_ADDR_IRQ_STAT: s_axi_rdata <= {{(32-`FASF_FLAG_W){1'b0}}, irq_stat_ff};
               `FASF_ADDR_IRQ_MASK: s_axi_rdata <= {{(32-`FASF_FLAG_W){1'b0}}, irq_mask_ff};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `FASF_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // fasf_unit

//--- bench/fasf_core_model.sv
// core register-file stand-in: captures destination writes of the unit
// assumes write strobes are one-cycle pulses on aclk
`timescale 1ns/1ns
module fasf_core_model (
   input  wire        aclk,
   input  wire        abs_wr_ff,
   input  wire [31:0] abs_res_ff,
   input  wire        sgn_wr_ff,
   input  wire [31:0] sgn_res_ff,
   output reg  [31:0] abs_dest_ff = 32'h5a5a5a5a,
   output reg  [31:0] sgn_dest_ff = 32'h5a5a5a5a
);
   // a non-zero start value so a missing first write cannot pass as zero
   always @(posedge aclk)
   begin
      if (abs_wr_ff)
         abs_dest_ff <= abs_res_ff;
      if (sgn_wr_ff)
         sgn_dest_ff <= sgn_res_ff;
   end
endmodule // fasf_core_model

//--- bench/fasf_unit_monitor.sv
// checker for the abs / sign-flags unit, bound into fasf_unit
// assumes ce is not dropped while an abs result is in flight
`timescale 1ns/1ns
`include "fasf_map.vh"
module fasf_unit_monitor (
   input wire                    aclk,
   input wire                    aresetn,
   input wire                    ce,
   input wire                    abs_issue,
   input wire                    abs_flags_only,
   input wire [31:0]             abs_src,
   input wire                    abs_guarded,
   input wire [31:0]             abs_guard,
   input wire                    sgn_issue,
   input wire                    sgn_guarded,
   input wire [31:0]             sgn_guard,
   input wire [`FASF_FLAG_W-1:0] ext_flag_upd,
   input wire                    abs_wr_ff,
   input wire [31:0]             abs_res_ff,
   input wire                    sgn_wr_ff,
   input wire [31:0]             sgn_res_ff,
   input wire [`FASF_FLAG_W-1:0] status_word_ff,
   input wire                    s_axi_bvalid
);
   wire abs_ok = !abs_guarded || abs_guard[0];
   wire sgn_ok = !sgn_guarded || sgn_guard[0];
   wire abs_go = ce && abs_issue && abs_ok;
   wire sgn_go = ce && sgn_issue && sgn_ok;
   wire [7:0] ex = abs_src[30:23];
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_abs_latency: assert property (abs_go |-> ##3 abs_wr_ff)
      else $error("abs write not three cycles after issue");
   a_abs_magnitude: assert property (abs_go && !abs_flags_only && ex != 8'h00 && ex != 8'hff
      |-> ##3 abs_res_ff == {1'b0, $past(abs_src[30:0], 3)}) else $error("abs magnitude wrong");
   a_abs_flush: assert property (abs_go && !abs_flags_only && ex == 8'h00 && abs_src[22:0] != 23'h0
      |-> ##3 abs_res_ff == 32'h0 && status_word_ff[`FASF_IFZ_BIT]) else $error("denormal not flushed");
   a_abs_guard: assert property (abs_wr_ff |-> $past(abs_issue, 3) && $past(abs_ok, 3))
      else $error("abs write without enabled issue");
   a_flag_sticky: assert property (|($past(status_word_ff) & ~status_word_ff) |-> ##[0:2] s_axi_bvalid)
      else $error("status flag dropped without a write");
   a_flag_merge: assert property (ext_flag_upd != 7'h0
      |=> (status_word_ff & $past(ext_flag_upd)) == $past(ext_flag_upd)) else $error("flag update lost");
   a_sgn_latency: assert property (sgn_go |=> sgn_wr_ff)
      else $error("sign write not one cycle after issue");
   a_sgn_guard: assert property (sgn_wr_ff |-> $past(sgn_issue) && $past(sgn_ok))
      else $error("sign write without enabled issue");
   a_sgn_vector: assert property (sgn_wr_ff |-> sgn_res_ff[31:7] == 25'h0)
      else $error("sign vector upper bits set");
   a_sgn_hold: assert property (!sgn_wr_ff |-> $stable(sgn_res_ff))
      else $error("sign result moved without write");
endmodule // fasf_unit_monitor
bind fasf_unit fasf_unit_monitor u_mon (.aclk, .aresetn, .ce, .abs_issue, .abs_flags_only, .abs_src, .abs_guarded,
   .abs_guard, .sgn_issue, .sgn_guarded, .sgn_guard, .ext_flag_upd, .abs_wr_ff, .abs_res_ff, .sgn_wr_ff,
   .sgn_res_ff, .status_word_ff, .s_axi_bvalid);

//--- bench/fasf_unit_tb.sv
// self-checking bench for the abs / sign-flags unit
// assumes the core model as destination register file, ce held high except in t_ce
`timescale 1ns/1ns
module fasf_unit_tb;
   reg         aclk = 0, aresetn = 0, ce = 1, abs_issue = 0, abs_flags_only = 0, abs_guarded = 0;
   reg         sgn_issue = 0, sgn_guarded = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   reg  [31:0] abs_src = 0, abs_guard = 0, sgn_src = 0, sgn_guard = 0, s_axi_wdata = 0, r;
   reg  [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   reg  [6:0]  ext_flag_upd = 0;
   reg  [1:0]  e;
   wire        abs_wr_ff, sgn_wr_ff, irq_ff, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [31:0] abs_res_ff, sgn_res_ff, s_axi_rdata, dabs, dsg;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [6:0]  status_word_ff;
   integer     n_fail = 0, checked = 0;
   always #50 aclk = ~aclk;
   fasf_unit uut (.aclk, .aresetn, .ce, .abs_issue, .abs_flags_only, .abs_src, .abs_guarded, .abs_guard, .sgn_issue,
      .sgn_src, .sgn_guarded, .sgn_guard, .ext_flag_upd, .abs_wr_ff, .abs_res_ff, .sgn_wr_ff, .sgn_res_ff,
      .status_word_ff, .irq_ff, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1));
   fasf_core_model core (.aclk, .abs_wr_ff, .abs_res_ff, .sgn_wr_ff, .sgn_res_ff, .abs_dest_ff(dabs), .sgn_dest_ff(dsg));
   task conclude;
   begin
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   task chk(input string nm, input [31:0] got, input [31:0] exp);
   begin
      checked = checked + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   end
   endtask
   // ready lines pulse for one cycle only, so each valid is dropped once its ready has been seen
   task axw(input [3:0] a, input [31:0] d);
      integer i;
   begin
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; i = 0;
      do begin
         @(posedge aclk); i = i + 1;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid && i < 40);
      e = s_axi_bresp;
      if (!s_axi_bvalid) begin n_fail = n_fail + 1; conclude; end
   end
   endtask
   task axr(input [3:0] a);
      integer i;
   begin
      s_axi_araddr <= a; s_axi_arvalid <= 1; i = 0;
      do begin
         @(posedge aclk); i = i + 1;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid && i < 40);
      r = s_axi_rdata; e = s_axi_rresp;
      if (!s_axi_rvalid) begin n_fail = n_fail + 1; conclude; end
   end
   endtask
   task ab(input [31:0] s, input gd, input [31:0] g, input fo);
   begin
      abs_src <= s; abs_guarded <= gd; abs_guard <= g; abs_flags_only <= fo; abs_issue <= 1;
      @(posedge aclk); abs_issue <= 0;
      repeat (5) @(posedge aclk);
   end
   endtask
   task sg(input [31:0] s, input gd, input [31:0] g);
   begin
      sgn_src <= s; sgn_guarded <= gd; sgn_guard <= g; sgn_issue <= 1;
      @(posedge aclk); sgn_issue <= 0;
      repeat (3) @(posedge aclk);
   end
   endtask
   task t_abs;
   begin
      ab(32'h40400000, 0, 0, 0); chk("abs pos", dabs, 32'h40400000);
      ab(32'hbf800000, 0, 0, 0); chk("abs neg", dabs, 32'h3f800000);
      ab(32'h00400000, 0, 0, 0); chk("abs denorm", dabs, 0);
      chk("psw ifz", status_word_ff, 32'h20);
      ab(32'hffffffff, 0, 0, 0); chk("abs qnan", dabs, 32'hffffffff);
      ab(32'hffbfffff, 0, 0, 0); chk("abs snan", dabs, 32'hffffffff);
      ab(32'hff7fffff, 1, 32'h2, 0); chk("abs guard off", dabs, 32'hffffffff);
      ab(32'hff7fffff, 1, 32'h1, 0); chk("abs guard on", dabs, 32'h7f7fffff);
      axr(4'h0); chk("psw sticky", r, 32'h30);
      axw(4'h0, 0); axr(4'h0); chk("psw cleared", r, 0);
      ab(32'h00400000, 1, 32'h2, 0); chk("psw guard off", status_word_ff, 0);
      ab(32'hffbfffff, 0, 0, 1); chk("flags snan", dabs, 32'h10);
      ab(32'h00400000, 0, 0, 1); chk("flags denorm", dabs, 32'h20);
      chk("psw flags op", status_word_ff, 0);
   end
   endtask
   task t_sgn;
   begin
      sg(32'h40400000, 0, 0); chk("sgn pos", dsg, 0);
      sg(32'h80400000, 0, 0); chk("sgn denorm", dsg, 32'h20);
      sg(32'h80800000, 0, 0); chk("sgn normal", dsg, 0);
      sg(32'hffffffff, 1, 1); chk("sgn nan", dsg, 32'h10);
      sg(32'hff800000, 1, 32'h2); chk("sgn guard off", dsg, 32'h10);
      sg(32'hff800000, 0, 0); chk("sgn inf", dsg, 0);
      chk("psw after sgn", status_word_ff, 0);
   end
   endtask
   // an issue while ce is low must not be taken
   task t_ce;
   begin
      ce <= 0; sgn_src <= 32'h00400000; sgn_guarded <= 0; sgn_issue <= 1;
      @(posedge aclk); sgn_issue <= 0;
      repeat (2) @(posedge aclk); ce <= 1;
      repeat (2) @(posedge aclk); chk("ce frozen", dsg, 0);
   end
   endtask
   task t_or;
   begin
      abs_src <= 32'h00400000; abs_guarded <= 0; abs_flags_only <= 0; abs_issue <= 1;
      @(posedge aclk); abs_issue <= 0;
      repeat (1) @(posedge aclk); ext_flag_upd <= 7'h48;
      @(posedge aclk); ext_flag_upd <= 0;
      repeat (2) @(posedge aclk); chk("psw merge", status_word_ff, 32'h68);
   end
   endtask
   task t_irq;
   begin
      axw(4'h8, 0); axw(4'h4, 32'h7f); axr(4'h4); chk("irq stat clear", r, 0);
      ext_flag_upd <= 7'h01; @(posedge aclk); ext_flag_upd <= 0;
      repeat (3) @(posedge aclk); chk("irq masked", irq_ff, 0);
      axr(4'h4); chk("irq stat set", r, 1);
      axw(4'h8, 1); repeat (3) @(posedge aclk); chk("irq on", irq_ff, 1);
      axw(4'h4, 1); repeat (3) @(posedge aclk); chk("irq off", irq_ff, 0);
      axr(4'hc); chk("unmapped resp", e, 2'h2); chk("unmapped data", r, 0);
      axw(4'hc, 1); chk("unmapped wr", e, 2'h2);
   end
   endtask
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      t_abs;
      t_sgn;
      t_ce;
      t_or;
      t_irq;
      conclude;
   end
endmodule // fasf_unit_tb
